// *** hdl/gpm_pkg.sv ***
// Package with pin maps, masks and reset values of the GPIO direction mux
package gpm_pkg;
    localparam int NPINS = 50;
    // Pins that exist at all
    localparam logic [49:0] IMPL_MASK = 50'h3_0305_1bff_ffff;
    // Input-only pins
    localparam logic [49:0] IN_MASK   = 50'h0_0300_0000_ffff;
    // Output-only pins (push-pull and open-drain)
    localparam logic [49:0] OUT_MASK  = 50'h3_0000_00ff_0000;
    // Bidirectional pins
    localparam logic [49:0] BIDIR_MASK = 50'h0_0005_1b00_0000;
    // Open-drain outputs
    localparam logic [49:0] OD_MASK   = 50'h2_0000_0040_0000;
    // Pins that have a native alternate function
    localparam logic [49:0] ALT_MASK  = 50'h3_0300_0003_ce3f;
    // Reset values
    localparam logic [49:0] RST_SEL   = 50'h0;
    localparam logic [49:0] RST_DIR   = 50'h0;
    localparam logic [49:0] RST_DATA  = 50'h0;
    localparam logic [49:0] RST_INV   = 50'h0;
    // Selector codes for pins 17 and 1
    localparam logic [1:0] MUX_GPIO   = 2'h0;
    localparam logic [1:0] MUX_LEGACY = 2'h1;
    localparam logic [1:0] MUX_PCI5   = 2'h2;
    localparam int SYNC_STAGES = 3;
endpackage : gpm_pkg

// *** hdl/gpm_sync.sv ***
// Three-flop input synchroniser with second/third agreement filter
module gpm_sync #(
    parameter int                W    = 1,
    parameter logic [W-1:0]      INIT = '0
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_ce,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] s1_q, s2_q, s3_q, out_q;
    logic [W-1:0] out_d;

    always_comb begin
        // Only a value seen in two consecutive stages is accepted
        out_d = out_q;
        for (int b = 0; b < W; b++) begin
            if (s2_q[b] == s3_q[b]) begin
                out_d[b] = s3_q[b];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_q  <= INIT;
            s2_q  <= INIT;
            s3_q  <= INIT;
            out_q <= INIT;
        end else if (i_ce) begin
            s1_q  <= i_async;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            out_q <= out_d;
        end
    end

    assign o_sync = out_q;
endmodule : gpm_sync

// *** hdl/gpm_top.sv ***
// GPIO port with fixed and software-selected pin directions and native-function pin multiplexing
module gpm_top
    import gpm_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                I_MCLK,
    input  wire logic                I_RESETN,
    input  wire logic                I_CE,
    // Configuration from the system
    input  wire logic [49:0]         I_NATIVE_SEL,
    input  wire logic                I_PIN17_PCI5,
    input  wire logic                I_PIN1_PCI5,
    input  wire logic [49:0]         I_DIR_OUT,
    input  wire logic [49:0]         I_OUT_DATA,
    input  wire logic [49:0]         I_IN_INVERT,
    // Native function outputs toward pins
    input  wire logic                I_PROCESSOR_POWER_GOOD,
    input  wire logic                I_PCI_GRANT_FOUR,
    input  wire logic [1:0]          I_LEGACY_GRANT,
    input  wire logic                I_PCI_GRANT_FIVE,
    // Pads
    input  wire logic [49:0]         I_PAD,
    output logic      [49:0]         O_PAD,
    output logic      [49:0]         O_PAD_OE,
    // GPIO read-back and native inputs
    output logic      [49:0]         O_IN_DATA,
    output logic      [49:0]         O_SEL_RB,
    output logic                     O_LPC_DMA_REQUEST_ONE,
    output logic                     O_PCI_REQUEST_FOUR,
    output logic      [1:0]          O_USB_OVERCURRENT_HIGH,
    output logic      [1:0]          O_USB_OVERCURRENT_LOW,
    output logic                     O_SMBUS_ALERT_INPUT,
    output logic      [3:0]          O_PCI_INTERRUPT_LINES_E_TO_H,
    output logic      [1:0]          O_LEGACY_REQUEST,
    output logic                     O_PCI_REQUEST_FIVE
);
    // ****************************************************************
    // Configuration state
    // ****************************************************************
    logic [49:0] sel_q;
    logic [49:0] sel_d;
    logic [49:0] dir_q;
    logic [49:0] dir_d;
    logic [49:0] dat_q;
    logic [49:0] dat_d;
    logic [49:0] inv_q;
    logic [49:0] inv_d;
    // Pin 17 and pin 1 choose between the legacy and the fifth PCI pair
    logic        p17_q;
    logic        p17_d;
    logic        p1_q;
    logic        p1_d;

    always_comb begin
        // Bits of absent pins never store, so they read back zero
        sel_d = I_NATIVE_SEL & ALT_MASK & IMPL_MASK;
        dir_d = (I_DIR_OUT & BIDIR_MASK) | OUT_MASK;
        dat_d = I_OUT_DATA & (OUT_MASK | BIDIR_MASK);
        inv_d = I_IN_INVERT & IMPL_MASK;
        p17_d = I_PIN17_PCI5 & I_NATIVE_SEL[17];
        p1_d  = I_PIN1_PCI5 & I_NATIVE_SEL[1];
    end

    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            sel_q <= RST_SEL;
            dir_q <= RST_DIR | OUT_MASK;
            dat_q <= RST_DATA;
            inv_q <= RST_INV;
            p17_q <= 1'b0;
            p1_q  <= 1'b0;
        end else if (I_CE) begin
            sel_q <= sel_d;
            dir_q <= dir_d;
            dat_q <= dat_d;
            inv_q <= inv_d;
            p17_q <= p17_d;
            p1_q  <= p1_d;
        end
    end

    // ****************************************************************
    // Pad inputs
    // ****************************************************************
    logic [49:0] pad_s;

    // Pads are asynchronous; a change is taken only once two stages agree
    // Costs four cycles of input latency, but single-cycle glitches never reach software
    gpm_sync #(.W(NPINS), .INIT(50'h0)) u_sync (
        .i_clk   (I_MCLK),
        .i_rst_n (I_RESETN),
        .i_ce    (I_CE),
        .i_async (I_PAD),
        .o_sync  (pad_s)
    );

    // ****************************************************************
    // Output drive and input routing
    // ****************************************************************
    logic [49:0] src;
    logic [49:0] pad_d;
    logic [49:0] oe_d;
    logic [49:0] in_d;
    logic [49:0] pad_q;
    logic [49:0] oe_q;
    logic [49:0] in_q;
    logic        ldrq_d;
    logic        pci_request_four_d;
    logic        smb_d;
    logic        pci_request_five_d;
    logic [1:0]  och_d;
    logic [1:0]  ocl_d;
    logic [1:0]  lreq_d;
    logic [3:0]  pirq_d;
    logic        ldrq_q;
    logic        pci_request_four_q;
    logic        smb_q;
    logic        pci_request_five_q;
    logic [1:0]  och_q;
    logic [1:0]  ocl_q;
    logic [1:0]  lreq_q;
    logic [3:0]  pirq_q;

    always_comb begin
        src = dat_q;
        if (sel_q[49]) begin
            src[49] = I_PROCESSOR_POWER_GOOD;
        end
        if (sel_q[48]) begin
            src[48] = I_PCI_GRANT_FOUR;
        end
        if (sel_q[17]) begin
            src[17] = p17_q ? I_PCI_GRANT_FIVE : I_LEGACY_GRANT[0];
        end
        if (sel_q[16]) begin
            src[16] = I_LEGACY_GRANT[1];
        end
        // Open-drain pins drive only low; high is released to the pull-up
        pad_d = src & ~OD_MASK;
        oe_d  = dir_q & IMPL_MASK & ~(OD_MASK & src);
        // GPIO sees only pins not handed to a native function
        in_d  = (pad_s ^ inv_q) & (IN_MASK | BIDIR_MASK) & ~sel_q;
        // Unselected native inputs idle high, so no request is seen
        ldrq_d = sel_q[41] ? pad_s[41] : 1'b1;
        pci_request_four_d = sel_q[40] ? pad_s[40] : 1'b1;
        och_d  = {sel_q[15] ? pad_s[15] : 1'b1,
                  sel_q[14] ? pad_s[14] : 1'b1};
        smb_d  = sel_q[11] ? pad_s[11] : 1'b1;
        ocl_d  = {sel_q[10] ? pad_s[10] : 1'b1,
                  sel_q[9]  ? pad_s[9]  : 1'b1};
        for (int k = 0; k < 4; k++) begin
            pirq_d[k] = sel_q[5-k] ? pad_s[5-k] : 1'b1;
        end
        lreq_d[0] = (sel_q[1] && !p1_q) ? pad_s[1] : 1'b1;
        lreq_d[1] = sel_q[0] ? pad_s[0] : 1'b1;
        pci_request_five_d    = (sel_q[1] && p1_q) ? pad_s[1] : 1'b1;
    end

    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            pad_q  <= 50'h0;
            oe_q   <= 50'h0;
            in_q   <= 50'h0;
            ldrq_q <= 1'b1;
            pci_request_four_q <= 1'b1;
            och_q  <= 2'h3;
            smb_q  <= 1'b1;
            ocl_q  <= 2'h3;
            pirq_q <= 4'hf;
            lreq_q <= 2'h3;
            pci_request_five_q <= 1'b1;
        end else if (I_CE) begin
            pad_q  <= pad_d;
            oe_q   <= oe_d;
            in_q   <= in_d;
            ldrq_q <= ldrq_d;
            pci_request_four_q <= pci_request_four_d;
            och_q  <= och_d;
            smb_q  <= smb_d;
            ocl_q  <= ocl_d;
            pirq_q <= pirq_d;
            lreq_q <= lreq_d;
            pci_request_five_q <= pci_request_five_d;
        end
    end

    // ****************************************************************
    // Top-level outputs
    // ****************************************************************
    // Pins 13, 12, 8, 7, 6 stay plain inputs: not in ALT_MASK
    assign O_PAD    = pad_q;
    assign O_PAD_OE = oe_q;
    assign O_IN_DATA = in_q;
    assign O_SEL_RB = sel_q;
    assign O_LPC_DMA_REQUEST_ONE = ldrq_q;
    assign O_PCI_REQUEST_FOUR = pci_request_four_q;
    assign O_USB_OVERCURRENT_HIGH = och_q;
    assign O_USB_OVERCURRENT_LOW = ocl_q;
    assign O_SMBUS_ALERT_INPUT = smb_q;
    assign O_PCI_INTERRUPT_LINES_E_TO_H = pirq_q;
    assign O_LEGACY_REQUEST = lreq_q;
    assign O_PCI_REQUEST_FIVE = pci_request_five_q;
endmodule : gpm_top

// *** sim/gpm_top_props.sv ***
// Port-level assertions for the GPIO direction mux
module gpm_top_props (
    // Clock, reset, enable
    input wire logic        I_MCLK,
    input wire logic        I_RESETN,
    input wire logic        I_CE,
    // Configuration and native outputs
    input wire logic [49:0] I_NATIVE_SEL,
    input wire logic        I_PIN17_PCI5,
    input wire logic        I_PIN1_PCI5,
    input wire logic [49:0] I_DIR_OUT,
    input wire logic [49:0] I_OUT_DATA,
    input wire logic [49:0] I_IN_INVERT,
    input wire logic        I_PROCESSOR_POWER_GOOD,
    input wire logic        I_PCI_GRANT_FOUR,
    // Pads and read-back
    input wire logic [49:0] I_PAD,
    input wire logic [49:0] O_PAD,
    input wire logic [49:0] O_PAD_OE,
    input wire logic [49:0] O_IN_DATA,
    input wire logic [49:0] O_SEL_RB,
    input wire logic        O_SMBUS_ALERT_INPUT
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [49:0] IMP = 50'h3_0305_1bff_ffff;
    localparam logic [49:0] INP = 50'h0_0300_0000_ffff;
    localparam logic [49:0] BID = 50'h0_0005_1b00_0000;
    localparam logic [49:0] MUX = 50'h3_0300_0003_ce3f;
    logic [201:0] cfg, cfg_q;
    logic [49:0]  pad_q;
    logic [2:0]   cs_q, cs_d, ps_q, ps_d;
    logic         steady, padok;
    assign cfg = {I_NATIVE_SEL, I_PIN17_PCI5, I_PIN1_PCI5, I_DIR_OUT,
                  I_OUT_DATA, I_IN_INVERT};
    // Held long enough to cross the config and pad pipelines
    assign steady = I_CE && cfg == cfg_q && cs_q >= 3'h3;
    assign padok  = I_PAD == pad_q && ps_q >= 3'h6;
    always_comb begin
        cs_d = (I_CE && cfg == cfg_q) ? cs_q + {2'h0, cs_q != 3'h7} : 3'h0;
        ps_d = (I_CE && I_PAD == pad_q) ? ps_q + {2'h0, ps_q != 3'h7} : 3'h0;
    end
    always_ff @(posedge I_MCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            cfg_q <= '0;
            pad_q <= '0;
            cs_q  <= 3'h0;
            ps_q  <= 3'h0;
        end else begin
            cfg_q <= cfg;
            pad_q <= I_PAD;
            cs_q  <= cs_d;
            ps_q  <= ps_d;
        end
    end
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RESETN);
    property p_od_low; O_PAD[49] == 1'b0 && O_PAD[22] == 1'b0; endproperty
    property p_in_noe; (O_PAD_OE & INP) == '0; endproperty
    property p_absent;
        ((O_PAD_OE | O_PAD | O_IN_DATA | O_SEL_RB) & ~IMP) == '0;
    endproperty
    property p_pp_oe; steady |-> O_PAD_OE[23] && O_PAD_OE[21:18] == 4'hf;
    endproperty
    property p_bidir; steady |-> (O_PAD_OE & BID) == (I_DIR_OUT & BID);
    endproperty
    property p_sel; steady |-> O_SEL_RB == (I_NATIVE_SEL & MUX); endproperty
    property p_pci_grant_four;
        steady && I_NATIVE_SEL[48] |-> O_PAD[48] == $past(I_PCI_GRANT_FOUR);
    endproperty
    property p_pwrgd; steady && I_NATIVE_SEL[49] |->
        O_PAD_OE[49] == !$past(I_PROCESSOR_POWER_GOOD); endproperty
    property p_gpin; steady && padok |->
        (O_IN_DATA & INP & ~(I_NATIVE_SEL & MUX))
        == ((I_PAD ^ I_IN_INVERT) & INP & ~(I_NATIVE_SEL & MUX));
    endproperty
    property p_smb; steady && padok |->
        O_SMBUS_ALERT_INPUT == (I_NATIVE_SEL[11] ? I_PAD[11] : 1'b1);
    endproperty
    a_od_low: assert property (p_od_low) else $error("od pad high");
    a_in_noe: assert property (p_in_noe) else $error("input driven");
    a_absent: assert property (p_absent) else $error("absent pin");
    a_pp_oe: assert property (p_pp_oe) else $error("output oe low");
    a_bidir: assert property (p_bidir) else $error("bidir oe");
    a_sel: assert property (p_sel) else $error("select readback");
    a_pci_grant_four: assert property (p_pci_grant_four) else $error("grant four");
    a_pwrgd: assert property (p_pwrgd) else $error("power good");
    a_gpin: assert property (p_gpin) else $error("gpio input");
    a_smb: assert property (p_smb) else $error("smbus alert");
    c_pci_grant_four: cover property (steady && I_NATIVE_SEL[48]);
    c_pwrgd: cover property (steady && I_NATIVE_SEL[49]);
    c_inv8: cover property (padok && I_IN_INVERT[8]);
endmodule : gpm_top_props

// *** sim/gpm_board.sv ***
// Board side of the pads: pull-ups and external drivers
module gpm_board (
    // Device pad drive
    input  wire logic [49:0] i_pad_out,
    input  wire logic [49:0] i_pad_oe,
    // Level the board drives on released pins
    input  wire logic [49:0] i_ext,
    output logic      [49:0] o_pad_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // Open-drain pins and grant pins 17 and 16 float to one when released
    localparam logic [49:0] PU = 50'h2_0000_0043_0000;
    assign o_pad_in = (i_pad_oe & i_pad_out) | (~i_pad_oe & PU) |
                      (~i_pad_oe & ~PU & i_ext);
endmodule : gpm_board

// *** sim/tb_gpm_top.sv ***
// Self-checking bench for the GPIO direction mux
module tb_gpm_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, rst_n, ce, p17, p1, pwr, g4, g5, lpc, r4, smb, r5;
    logic [49:0] sel, dir, dat, inv, ext, pad_in, pad, oe, ind, selrb;
    logic [1:0] lg, och, ocl, lrq;
    logic [3:0] pirq;
    int n_errors, checked, cyc;
    gpm_top i_dut (.I_MCLK(mclk), .I_RESETN(rst_n), .I_CE(ce),
        .I_NATIVE_SEL(sel), .I_PIN17_PCI5(p17), .I_PIN1_PCI5(p1),
        .I_DIR_OUT(dir), .I_OUT_DATA(dat), .I_IN_INVERT(inv),
        .I_PROCESSOR_POWER_GOOD(pwr), .I_PCI_GRANT_FOUR(g4),
        .I_LEGACY_GRANT(lg), .I_PCI_GRANT_FIVE(g5), .I_PAD(pad_in),
        .O_PAD(pad), .O_PAD_OE(oe), .O_IN_DATA(ind), .O_SEL_RB(selrb),
        .O_LPC_DMA_REQUEST_ONE(lpc), .O_PCI_REQUEST_FOUR(r4),
        .O_USB_OVERCURRENT_HIGH(och), .O_USB_OVERCURRENT_LOW(ocl),
        .O_SMBUS_ALERT_INPUT(smb), .O_PCI_INTERRUPT_LINES_E_TO_H(pirq),
        .O_LEGACY_REQUEST(lrq), .O_PCI_REQUEST_FIVE(r5));
    gpm_board i_board (.i_pad_out(pad), .i_pad_oe(oe), .i_ext(ext),
        .o_pad_in(pad_in));
    always #2.5 mclk = ~mclk;
    // Hang guard, far above the roughly fifty cycles the run needs
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            final_report();
        end
    end
    task automatic chk(input logic [49:0] got, input logic [49:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic settle();
        repeat (8) @(negedge mclk);
    endtask : settle
    task automatic t_outputs();
        dir = '1;
        dat = '1;
        settle();
        chk(oe, 50'h1_0005_1bbf_0000);
        chk(pad & oe, 50'h1_0005_1bbf_0000);
        // Clock enable low must freeze the drive
        ce = 1'b0;
        dat = '0;
        settle();
        chk(pad & oe, 50'h1_0005_1bbf_0000);
        ce = 1'b1;
        dir = '0;
        settle();
        chk(oe, 50'h3_0000_00ff_0000);
        chk(pad, 50'h0);
    endtask : t_outputs
    task automatic t_inputs();
        settle();
        chk(ind, 50'h0_0300_0000_a440);
    endtask : t_inputs
    task automatic t_native(input logic mode);
        sel = '1;
        dat = '1;
        p17 = mode;
        p1 = mode;
        settle();
        chk(selrb, 50'h3_0300_0003_ce3f);
        chk(ind, 50'h0_0000_0000_2040);
        chk({36'h0, lpc, r4, och, ocl, smb, pirq, lrq, r5},
            {36'h0, 4'h6, 3'h4, 4'h0, mode ? 3'h6 : 3'h5});
        chk({46'h0, oe[49], pad[48], pad[17:16]},
            {46'h0, 2'h0, mode ? 2'h3 : 2'h1});
    endtask : t_native
    task automatic final_report();
        if (n_errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report
    initial begin
        {mclk, rst_n, ce, p17, p1, g5} = 6'h09;
        {pwr, g4, lg} = 4'ha;
        {sel, dir, dat} = '0;
        inv = 50'h0_0200_0000_0181;
        ext = 50'h0_fdfa_e400_a5c1;
        repeat (5) @(negedge mclk);
        chk(oe, 50'h0);
        chk({36'h0, lpc, r4, och, ocl, smb, pirq, lrq, r5}, 50'h3fff);
        rst_n = 1'b1;
        t_outputs();
        t_inputs();
        t_native(1'b0);
        t_native(1'b1);
        final_report();
    end
endmodule : tb_gpm_top
bind gpm_top gpm_top_props i_props (.I_MCLK(I_MCLK), .I_RESETN(I_RESETN),
    .I_CE(I_CE), .I_NATIVE_SEL(I_NATIVE_SEL), .I_PIN17_PCI5(I_PIN17_PCI5),
    .I_PIN1_PCI5(I_PIN1_PCI5), .I_DIR_OUT(I_DIR_OUT), .I_PAD(I_PAD),
    .I_OUT_DATA(I_OUT_DATA), .I_IN_INVERT(I_IN_INVERT), .O_PAD(O_PAD),
    .I_PROCESSOR_POWER_GOOD(I_PROCESSOR_POWER_GOOD), .O_SEL_RB(O_SEL_RB),
    .I_PCI_GRANT_FOUR(I_PCI_GRANT_FOUR), .O_PAD_OE(O_PAD_OE),
    .O_IN_DATA(O_IN_DATA), .O_SMBUS_ALERT_INPUT(O_SMBUS_ALERT_INPUT));
